// ### hdl/dcc_top.sv
// Comparator control block: APB registers, change detect, pin routing
//
// Behaviour
// - Internal reference feeds both plus inputs only in mode 110.
// - Result bits 7:6 of control register are read only.
// - Routed results drive the pins unsynchronised.
// - Port direction bits still enable the routed pins.
// - Inversion bits 5:4 flip each comparator output.
// - Flag sets when either result differs from its latched value.
// - Flag at bit 6 stays until cleared; writing one sets it.
// - Interrupt needs flag enable, peripheral and global enables.
// - Race with a control read avoided: set always wins.
// - A standing mismatch keeps setting the flag.
// - Any control register access relatches results.
// - Active comparators keep detecting in sleep and wake the device.
// - Mode 111 powers both comparators off.
// - Waking from sleep leaves the control register unchanged.
// - Reset loads control register with mode 000.
// - Comparators held powered down during reset.
// - Port reads return zero for analog pins.
// - Input switch picks the minus input pair in mode 110.
// - Result is one when plus exceeds minus unless inverted.
// - Mode is the three bit field in bits 2-0.
`default_nettype none
module dcc_top
	import dcc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic first_cmp_raw,
	input wire logic second_cmp_raw,
	input wire logic [7:0] port_f_in,
	output logic [1:0] cmp_power_on,
	output logic ref_to_plus,
	output logic [1:0] first_minus_sel,
	output logic [1:0] second_minus_sel,
	output logic first_result_pin,
	output logic second_result_pin,
	output logic first_result_pin_oe_n,
	output logic second_result_pin_oe_n,
	output logic [1:0] pin_route,
	output logic cmp_irq,
	output logic wake_req
);
	import dcc_pkg::*;

	dcc_if dif ();

	// Software visible state
	logic [5:0] ctrl_rw;
	logic [5:0] next_ctrl_rw;
	logic cmp_change_flag;
	logic next_cmp_change_flag;
	logic [7:0] flags_other;
	logic [7:0] next_flags_other;
	logic [7:0] enables;
	logic [7:0] next_enables;
	logic [7:0] priority_r;
	logic [7:0] next_priority_r;
	logic [7:0] sysctrl;
	logic [7:0] next_sysctrl;
	logic [7:0] port_f_direction;
	logic [7:0] next_port_f_direction;
	dcc_state_e state;
	dcc_state_e next_state;
	logic [31:0] next_prdata;
	logic next_pslverr;

	// Result tracking
	logic [1:0] sync_a;
	logic [1:0] sync_b;
	logic [1:0] latched;
	logic [1:0] next_latched;
	logic [1:0] inv_res;
	logic [7:0] port_a;
	logic [7:0] port_b;
	logic [7:0] port_rd;

	// Outputs registered from decode
	logic [1:0] next_cmp_power_on;
	logic next_irq;

	assign dif.mode = ctrl_rw[DCC_MODE_MSB:DCC_MODE_LSB];
	assign dif.input_switch_select = ctrl_rw[DCC_CIS_BIT];

	dcc_mode_decode u_dec (
		.bus(dif.dec)
	);

	// Apply inversion to synchronised results
	assign inv_res = sync_b ^ ctrl_rw[DCC_INV_MSB:DCC_INV_LSB];

	// Port input synchroniser and analog masking
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_a <= DCC_REG_RST;
			port_b <= DCC_REG_RST;
		end else begin
			port_a <= port_f_in;
			port_b <= port_a;
		end
	end

	always_comb begin
		port_rd = port_b;
		port_rd[DCC_AN_MSB:DCC_AN_LSB] = port_b[DCC_AN_MSB:DCC_AN_LSB] &
			~dif.analog_pins;
	end

	// Two flop synchroniser for the raw comparator results
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_a <= 2'h0;
			sync_b <= 2'h0;
		end else begin
			sync_a <= {second_cmp_raw, first_cmp_raw};
			sync_b <= sync_a;
		end
	end

	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		hit = (a == o);
	endfunction : hit

	// APB access, register updates, change detect
	always_comb begin
		logic acc;
		logic wr;
		logic rd;
		logic mapped;
		acc = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		mapped = 1'b0;
		next_state = state;
		next_ctrl_rw = ctrl_rw;
		next_cmp_change_flag = cmp_change_flag;
		next_flags_other = flags_other;
		next_enables = enables;
		next_priority_r = priority_r;
		next_sysctrl = sysctrl;
		next_port_f_direction = port_f_direction;
		next_latched = latched;
		next_prdata = prdata;
		next_pslverr = 1'b0;
		case (state)
			DCC_ST_IDLE: begin
				if (psel && penable) begin
					acc = 1'b1;
					next_state = DCC_ST_DONE;
				end
			end
			DCC_ST_DONE: begin
				next_state = DCC_ST_IDLE;
			end
			default: begin
				next_state = DCC_ST_IDLE;
			end
		endcase
		wr = acc && pwrite;
		rd = acc && !pwrite;
		mapped = hit(paddr, DCC_OFF_CTRL) || hit(paddr, DCC_OFF_FLAGS) ||
			hit(paddr, DCC_OFF_ENABLES) || hit(paddr, DCC_OFF_PRIORITY) ||
			hit(paddr, DCC_OFF_SYSCTRL) || hit(paddr, DCC_OFF_PORTF);
		if (acc && !mapped) begin
			next_pslverr = 1'b1;
		end
		if (rd) begin
			next_prdata = DCC_RD_ZERO;
			if (hit(paddr, DCC_OFF_CTRL)) begin
				next_prdata[7:0] = {inv_res, ctrl_rw};
			end else if (hit(paddr, DCC_OFF_FLAGS)) begin
				next_prdata[7:0] = flags_other;
				next_prdata[DCC_CHG_BIT] = cmp_change_flag;
			end else if (hit(paddr, DCC_OFF_ENABLES)) begin
				next_prdata[7:0] = enables;
			end else if (hit(paddr, DCC_OFF_PRIORITY)) begin
				next_prdata[7:0] = priority_r;
			end else if (hit(paddr, DCC_OFF_SYSCTRL)) begin
				next_prdata[7:0] = sysctrl;
			end else if (hit(paddr, DCC_OFF_PORTF)) begin
				next_prdata[7:0] = port_rd;
			end
		end
		if (wr && hit(paddr, DCC_OFF_CTRL)) begin
			next_ctrl_rw = pwdata[5:0];
		end
		if (wr && hit(paddr, DCC_OFF_FLAGS)) begin
			next_flags_other = pwdata[7:0];
			next_flags_other[DCC_CHG_BIT] = 1'b0;
			next_cmp_change_flag = pwdata[DCC_CHG_BIT];
		end
		if (wr && hit(paddr, DCC_OFF_ENABLES)) begin
			next_enables = pwdata[7:0];
		end
		if (wr && hit(paddr, DCC_OFF_PRIORITY)) begin
			next_priority_r = pwdata[7:0];
		end
		if (wr && hit(paddr, DCC_OFF_SYSCTRL)) begin
			next_sysctrl = pwdata[7:0];
		end
		if (wr && hit(paddr, DCC_OFF_PORTF)) begin
			next_port_f_direction = pwdata[7:0];
		end
		// Any control access relatches the current results
		if (acc && hit(paddr, DCC_OFF_CTRL)) begin
			next_latched = inv_res;
		end
		// A mismatch sets the flag, winning over any clear
		if (inv_res != latched) begin
			next_cmp_change_flag = 1'b1;
		end
	end

	// Register state; control bits touched only by reset or write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= DCC_ST_IDLE;
			ctrl_rw <= DCC_CTRL_RST[5:0];
			cmp_change_flag <= 1'b0;
			flags_other <= DCC_REG_RST;
			enables <= DCC_REG_RST;
			priority_r <= DCC_REG_RST;
			sysctrl <= DCC_REG_RST;
			port_f_direction <= DCC_DIR_RST;
			latched <= 2'h0;
			prdata <= DCC_RD_ZERO;
			pslverr <= 1'b0;
		end else begin
			state <= next_state;
			ctrl_rw <= next_ctrl_rw;
			cmp_change_flag <= next_cmp_change_flag;
			flags_other <= next_flags_other;
			enables <= next_enables;
			priority_r <= next_priority_r;
			sysctrl <= next_sysctrl;
			port_f_direction <= next_port_f_direction;
			latched <= next_latched;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// Interrupt and wake request
	always_comb begin
		next_irq = cmp_change_flag && enables[DCC_CHG_BIT] &&
			sysctrl[DCC_PERIPHERAL_IRQ_ENABLE_BIT] && sysctrl[DCC_GIE_BIT];
		next_cmp_power_on = dif.cmp_power;
	end

	// Registered outputs; power held off in reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_power_on <= 2'h0;
			ref_to_plus <= 1'b0;
			first_minus_sel <= 2'h0;
			second_minus_sel <= 2'h0;
			pin_route <= 2'h0;
			first_result_pin_oe_n <= 1'b1;
			second_result_pin_oe_n <= 1'b1;
			cmp_irq <= 1'b0;
			wake_req <= 1'b0;
		end else begin
			cmp_power_on <= next_cmp_power_on;
			ref_to_plus <= dif.ref_to_plus;
			first_minus_sel <= dif.first_minus_sel;
			second_minus_sel <= dif.second_minus_sel;
			pin_route <= dif.pin_route;
			first_result_pin_oe_n <= port_f_direction[DCC_PIN_FIRST];
			second_result_pin_oe_n <= port_f_direction[DCC_PIN_SECOND];
			cmp_irq <= next_irq;
			wake_req <= next_irq && sysctrl[DCC_SLEEP_BIT];
		end
	end

	// Pin data: unsynchronised result with inversion, captured per clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_result_pin <= 1'b0;
			second_result_pin <= 1'b0;
		end else begin
			first_result_pin <= first_cmp_raw ^ ctrl_rw[DCC_INV_LSB];
			second_result_pin <= second_cmp_raw ^ ctrl_rw[DCC_INV_MSB];
		end
	end

	assign pready = (state == DCC_ST_DONE);
endmodule : dcc_top
`default_nettype wire

// ### hdl/dcc_pkg.sv
// Package with register map, field positions and modes of the comparator control
`default_nettype none
package dcc_pkg;
	// Register byte offsets on the APB bus
	localparam logic [11:0] DCC_OFF_CTRL = 12'h000;
	localparam logic [11:0] DCC_OFF_FLAGS = 12'h004;
	localparam logic [11:0] DCC_OFF_ENABLES = 12'h008;
	localparam logic [11:0] DCC_OFF_PRIORITY = 12'h00C;
	localparam logic [11:0] DCC_OFF_SYSCTRL = 12'h010;
	localparam logic [11:0] DCC_OFF_PORTF = 12'h014;
	// Comparator control field positions
	localparam int DCC_MODE_LSB = 0;
	localparam int DCC_MODE_MSB = 2;
	localparam int DCC_CIS_BIT = 3;
	localparam int DCC_INV_LSB = 4;
	localparam int DCC_INV_MSB = 5;
	localparam int DCC_OUT_LSB = 6;
	localparam int DCC_OUT_MSB = 7;
	// Flag and enable position in flags/enables registers
	localparam int DCC_CHG_BIT = 6;
	// System control bits
	localparam int DCC_PERIPHERAL_IRQ_ENABLE_BIT = 6;
	localparam int DCC_GIE_BIT = 7;
	localparam int DCC_SLEEP_BIT = 0;
	// Port F pin positions
	localparam int DCC_PIN_FIRST = 1;
	localparam int DCC_PIN_SECOND = 2;
	localparam int DCC_AN_LSB = 3;
	localparam int DCC_AN_MSB = 6;
	// Reset values
	localparam logic [7:0] DCC_CTRL_RST = 8'h00;
	localparam logic [7:0] DCC_REG_RST = 8'h00;
	localparam logic [7:0] DCC_DIR_RST = 8'hFF;
	localparam logic [31:0] DCC_RD_ZERO = 32'h0000_0000;
	// Comparator modes
	typedef enum logic [2:0] {
		DCC_MODE_RESET = 3'h0,
		DCC_MODE_REF_MUX = 3'h6,
		DCC_MODE_OFF = 3'h7
	} dcc_mode_e;
	// Access state of the APB slave
	typedef enum logic [1:0] {
		DCC_ST_IDLE = 2'h1,
		DCC_ST_DONE = 2'h2
	} dcc_state_e;
endpackage : dcc_pkg
`default_nettype wire

// ### hdl/dcc_if.sv
// Interface carrying mode and routing decode between top and decoder
`default_nettype none
interface dcc_if;
	logic [2:0] mode;
	logic input_switch_select;
	logic [1:0] cmp_power;
	logic ref_to_plus;
	logic [1:0] first_minus_sel;
	logic [1:0] second_minus_sel;
	logic [1:0] pin_route;
	logic [3:0] analog_pins;
	modport ctrl (output mode, output input_switch_select,
		input cmp_power, input ref_to_plus, input first_minus_sel,
		input second_minus_sel, input pin_route, input analog_pins);
	modport dec (input mode, input input_switch_select,
		output cmp_power, output ref_to_plus, output first_minus_sel,
		output second_minus_sel, output pin_route, output analog_pins);
endinterface : dcc_if
`default_nettype wire

// ### hdl/dcc_mode_decode.sv
// Mode decoder: comparator power, input muxing and pin routing per mode
`default_nettype none
module dcc_mode_decode
	import dcc_pkg::*;
(
	dcc_if.dec bus
);
	// Combinational decode of the mode field and input switch
	always_comb begin
		bus.cmp_power = 2'h3;
		bus.ref_to_plus = 1'b0;
		bus.first_minus_sel = 2'h0;
		bus.second_minus_sel = 2'h1;
		bus.pin_route = 2'h0;
		bus.analog_pins = 4'hF;
		case (bus.mode)
			DCC_MODE_RESET: begin
				bus.cmp_power = 2'h0; // Reset mode: all inputs analog
			end
			DCC_MODE_REF_MUX: begin
				bus.ref_to_plus = 1'b1;
				if (bus.input_switch_select) begin
					bus.first_minus_sel = 2'h2;
					bus.second_minus_sel = 2'h0;
				end else begin
					bus.first_minus_sel = 2'h3;
					bus.second_minus_sel = 2'h1;
				end
			end
			DCC_MODE_OFF: begin
				bus.cmp_power = 2'h0;
				bus.analog_pins = 4'h0;
			end
			3'h3, 3'h5: begin
				bus.pin_route = 2'h3; // Modes that drive results to pins
			end
			default: begin
				bus.cmp_power = 2'h3;
			end
		endcase
	end
endmodule : dcc_mode_decode
`default_nettype wire

// ### bench/dcc_cmp_model.sv
// Behavioural comparator cores and port F pin drivers
`default_nettype none
module dcc_cmp_model (
	input wire logic [1:0] power,
	input wire logic ref_on,
	input wire logic [1:0] sel1,
	input wire logic [1:0] sel2,
	input wire logic [3:0][7:0] an,
	input wire logic [7:0] vref,
	input wire logic [7:0] ext,
	input wire logic pin1,
	input wire logic pin2,
	input wire logic oe1_n,
	input wire logic oe2_n,
	output logic raw1,
	output logic raw2,
	output logic [7:0] pins
);
	// Plus input is the reference in the shared reference mode
	logic [7:0] plus;
	assign plus = ref_on ? vref : an[0];
	// High when plus exceeds minus; a powered-down core stays low
	assign raw1 = power[0] && (plus > an[sel1]);
	assign raw2 = power[1] && (plus > an[sel2]);
	// Direction bits gate the result drivers onto the pins
	always_comb begin
		pins = ext;
		if (!oe1_n) begin
			pins[1] = pin1;
		end
		if (!oe2_n) begin
			pins[2] = pin2;
		end
	end
endmodule : dcc_cmp_model
`default_nettype wire

// ### bench/dcc_top_props.sv
// Checker watching the comparator control ports
`default_nettype none
module dcc_top_props
	import dcc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic first_cmp_raw,
	input wire logic [1:0] cmp_power_on,
	input wire logic ref_to_plus,
	input wire logic first_result_pin,
	input wire logic first_result_pin_oe_n,
	input wire logic cmp_irq,
	input wire logic wake_req
);
	// Shadows of written registers, age since the last write
	logic [7:0] sc, se, ss, sd;
	logic [1:0] age;
	wire done = psel && penable && pready;
	wire ok = age == 2'h3;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sc <= 8'h00;
			se <= 8'h00;
			ss <= 8'h00;
			sd <= 8'hFF;
			age <= 2'h0;
		end else if (done && pwrite) begin
			age <= 2'h0;
			case (paddr)
				DCC_OFF_CTRL: sc <= pwdata[7:0];
				DCC_OFF_ENABLES: se <= pwdata[7:0];
				DCC_OFF_SYSCTRL: ss <= pwdata[7:0];
				DCC_OFF_PORTF: sd <= pwdata[7:0];
				default: ;
			endcase
		end else if (!ok) begin
			age <= age + 2'h1;
		end
	end
	default clocking dc @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_wait;
		psel && penable && !pready;
	endsequence
	chk_ready_wait: assert property (s_wait |=> pready)
		else $error("pready late");
	chk_reset_quiet: assert property ($rose(presetn) |->
		cmp_power_on == 2'h0 && !cmp_irq) else $error("reset power");
	chk_ref_mode: assert property (ok |->
		ref_to_plus == (sc[2:0] == 3'h6)) else $error("ref mode");
	chk_off_mode: assert property (ok && sc[2:0] == 3'h7 |->
		cmp_power_on == 2'h0) else $error("off mode");
	chk_irq_gate: assert property (ok && cmp_irq |->
		se[6] && ss[7] && ss[6]) else $error("irq gate");
	chk_wake_sleep: assert property (ok && $stable(cmp_irq) |->
		wake_req == (cmp_irq && ss[0])) else $error("wake");
	chk_pin_follow: assert property (ok |->
		first_result_pin == ($past(first_cmp_raw) ^ sc[4]))
		else $error("pin value");
	chk_pin_enable: assert property (ok |->
		first_result_pin_oe_n == sd[1]) else $error("pin enable");
endmodule : dcc_top_props
bind dcc_top dcc_top_props u_dcc_top_props (.*);
`default_nettype wire

// ### bench/dcc_tb_top.sv
// Self-checking bench of the comparator control block
`default_nettype none
module dcc_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import dcc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rv;
	logic r1, r2, p1, p2, o1, o2, rts, irq, wake, err;
	logic [1:0] pwr, s1, s2, route;
	logic [7:0] pf, vref;
	int n_fail, tests_run, cyc;
	// Block and its far side
	dcc_top u_dcc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .first_cmp_raw(r1), .second_cmp_raw(r2),
		.port_f_in(pf), .cmp_power_on(pwr), .ref_to_plus(rts),
		.first_minus_sel(s1), .second_minus_sel(s2),
		.first_result_pin(p1), .second_result_pin(p2),
		.first_result_pin_oe_n(o1), .second_result_pin_oe_n(o2),
		.pin_route(route), .cmp_irq(irq), .wake_req(wake));
	dcc_cmp_model u_dcc_cmp_model (.power(pwr), .ref_on(rts), .sel1(s1),
		.sel2(s2), .an({4{8'h80}}), .vref(vref), .ext(8'hFF),
		.pin1(p1), .pin2(p2), .oe1_n(o1), .oe2_n(o2), .raw1(r1),
		.raw2(r2), .pins(pf));
	// Clock and hang guard
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			final_report();
		end
	end
	// Verdict
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report
	// Compare and count
	task automatic check(input string nm, input logic [31:0] s, e);
		tests_run++;
		if (s !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask : check
	// One APB transfer, held until pready
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk);
		while (pready !== 1'b1);
		rv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [7:0] e,
		input string nm);
		apb(1'b0, a, 32'h0);
		check(nm, rv, {24'h0, e});
	endtask : rd
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask : wt
	// Move the reference and let the results settle
	task automatic lvl(input logic [7:0] v);
		@(posedge pclk);
		vref <= v;
		wt(8);
	endtask : lvl
	// Reset values, analog pins and an unmapped read
	task automatic t_reset();
		rd(DCC_OFF_CTRL, 8'h00, "ctrl");
		check("pslverr", {31'h0, err}, 32'h0);
		rd(DCC_OFF_FLAGS, 8'h00, "flags");
		rd(DCC_OFF_PORTF, 8'h87, "portf");
		rd(12'h020, 8'h00, "unmapped");
		check("pslverr", {31'h0, err}, 32'h1);
	endtask : t_reset
	// Reference routing, input switch and off mode
	task automatic t_mode();
		wr(DCC_OFF_CTRL, 8'h06);
		wt(2);
		check("ref", {31'h0, rts}, 32'h1);
		check("sel", {28'h0, s1, s2}, 32'hD);
		wr(DCC_OFF_CTRL, 8'h0E);
		wt(2);
		check("sel", {28'h0, s1, s2}, 32'h8);
		check("route", {30'h0, route}, 32'h0);
		wr(DCC_OFF_CTRL, 8'h03);
		wt(2);
		check("route", {30'h0, route}, 32'h3);
		wr(DCC_OFF_CTRL, 8'h07);
		wt(2);
		check("pwr", {29'h0, rts, pwr}, 32'h0);
		rd(DCC_OFF_PORTF, 8'hFF, "portf");
	endtask : t_mode
	// Read-only results, inversion and pin output
	task automatic t_out();
		wr(DCC_OFF_CTRL, 8'hC6);
		lvl(8'h70);
		rd(DCC_OFF_CTRL, 8'h06, "ctrl");
		lvl(8'h90);
		rd(DCC_OFF_CTRL, 8'hC6, "ctrl");
		check("pin", {31'h0, p1}, 32'h1);
		check("pin2", {31'h0, p2}, 32'h1);
		wr(DCC_OFF_CTRL, 8'h36);
		wt(3);
		rd(DCC_OFF_CTRL, 8'h36, "ctrl");
		check("pins", {30'h0, p1, p2}, 32'h0);
		wr(DCC_OFF_PORTF, 8'hF9);
		wt(3);
		check("oe", {30'h0, o1, o2}, 32'h0);
		rd(DCC_OFF_PORTF, 8'h81, "portf");
		wr(DCC_OFF_PORTF, 8'hFF);
	endtask : t_out
	// Change flag, standing mismatch, relatch, interrupt gating
	task automatic t_flag();
		wr(DCC_OFF_CTRL, 8'h06);
		rd(DCC_OFF_CTRL, 8'hC6, "ctrl");
		wr(DCC_OFF_FLAGS, 8'h00);
		rd(DCC_OFF_FLAGS, 8'h00, "flags");
		lvl(8'h70);
		rd(DCC_OFF_FLAGS, 8'h40, "flags");
		wr(DCC_OFF_FLAGS, 8'h00);
		rd(DCC_OFF_FLAGS, 8'h40, "flags");
		rd(DCC_OFF_CTRL, 8'h06, "ctrl");
		wr(DCC_OFF_FLAGS, 8'h00);
		rd(DCC_OFF_FLAGS, 8'h00, "flags");
		wr(DCC_OFF_FLAGS, 8'h40);
		rd(DCC_OFF_FLAGS, 8'h40, "flags");
		check("irq", {31'h0, irq}, 32'h0);
		wr(DCC_OFF_ENABLES, 8'h40);
		wr(DCC_OFF_SYSCTRL, 8'hC0);
		wt(2);
		check("irq", {31'h0, irq}, 32'h1);
		wr(DCC_OFF_SYSCTRL, 8'h80);
		wt(2);
		check("irq", {31'h0, irq}, 32'h0);
	endtask : t_flag
	// Wake on a change in sleep, control register kept
	task automatic t_sleep();
		wr(DCC_OFF_FLAGS, 8'h00);
		wr(DCC_OFF_SYSCTRL, 8'hC1);
		wt(2);
		check("wake", {31'h0, wake}, 32'h0);
		lvl(8'h90);
		check("wake", {31'h0, wake}, 32'h1);
		rd(DCC_OFF_CTRL, 8'hC6, "ctrl");
		wr(DCC_OFF_FLAGS, 8'h00);
		wt(2);
		check("wake", {31'h0, wake}, 32'h0);
	endtask : t_sleep
	// Second reset in mid-run
	task automatic t_rst2();
		lvl(8'h70);
		presetn <= 1'b0;
		wt(3);
		check("pwr", {30'h0, pwr}, 32'h0);
		presetn <= 1'b1;
		rd(DCC_OFF_CTRL, 8'h00, "ctrl");
	endtask : t_rst2
	// Main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		vref = 8'h70;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_mode();
		t_out();
		t_flag();
		t_sleep();
		t_rst2();
		final_report();
	end
endmodule : dcc_tb_top
`default_nettype wire
